// ===== core/dps_pkg.sv
// package: shared constants and carriers of the drive profile state machine
package dps_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_CFG = 4'h8;
  localparam logic [3:0] ADR_DRV = 4'hC;

  // ---------------------------------------------------------------
  // control word bit positions
  // ---------------------------------------------------------------
  localparam int CW_SO = 0;
  localparam int CW_EV = 1;
  localparam int CW_QS = 2;
  localparam int CW_EO = 3;
  localparam int CW_FR = 7;

  // ---------------------------------------------------------------
  // status word bit positions and state codes
  // ---------------------------------------------------------------
  localparam int SW_MODE_BAD = 14;
  localparam logic [6:0] SW_STATE_MASK = 7'h6F;
  localparam logic [6:0] SW_NOT_READY = 7'h00;
  localparam logic [6:0] SW_SO_DISABLED = 7'h40;
  localparam logic [6:0] SW_READY = 7'h21;
  localparam logic [6:0] SW_SWITCHED_ON = 7'h23;
  localparam logic [6:0] SW_OP_ENABLED = 7'h27;
  localparam logic [6:0] SW_QSTOP = 7'h07;
  localparam logic [6:0] SW_FAULT_REACT = 7'h0F;
  localparam logic [6:0] SW_FAULT = 7'h08;

  // ---------------------------------------------------------------
  // config register fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG_FIELDBUS = 0;
  localparam int CFG_SPEED_MODE = 1;
  localparam int CFG_NO_STOP_BITS = 2;
  localparam int CFG_PROFILE_MODE = 3;
  localparam logic [3:0] CFG_RESET = 4'hB;

  // ---------------------------------------------------------------
  // timing: self initialization length
  // ---------------------------------------------------------------
  localparam int INIT_NS = 80;
  localparam int CLK_NS = 8;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_RAMP,
    STOP_COAST,
    STOP_QUICK
  } dps_stop_t;

  typedef enum {
    ST_INIT,
    ST_NOT_READY,
    ST_SO_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QSTOP,
    ST_FAULT_REACT,
    ST_FAULT
  } dps_state_t;

  typedef struct packed {
    logic profile_mode;
    logic no_stop_bits;
    logic speed_mode;
    logic fieldbus;
  } dps_cfg_t;

  typedef struct packed {
    logic drive_enable;
    logic stop_req;
    dps_stop_t stop_kind;
  } dps_act_t;

endpackage : dps_pkg

// ===== core/dps_cmd_decode.sv
// module: control word command decoder
`timescale 1ns/1ps
module dps_cmd_decode (
  input wire logic [15:0] cw_i,
  output logic shutdown_o,
  output logic switch_on_o,
  output logic enable_op_o,
  output logic dis_voltage_o,
  output logic quick_stop_o,
  output logic fault_reset_o
);
  logic b7;
  logic b3;
  logic b2;
  logic b1;
  logic b0;

  assign b7 = cw_i[dps_pkg::CW_FR];
  assign b3 = cw_i[dps_pkg::CW_EO];
  assign b2 = cw_i[dps_pkg::CW_QS];
  assign b1 = cw_i[dps_pkg::CW_EV];
  assign b0 = cw_i[dps_pkg::CW_SO];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign shutdown_o = !b7 && b2 && b1 && !b0;
  assign switch_on_o = !b7 && !b3 && b2 && b1 && b0;
  assign enable_op_o = !b7 && b3 && b2 && b1 && b0;
  assign dis_voltage_o = !b7 && !b1;
  assign quick_stop_o = !b7 && !b2 && b1;
  assign fault_reset_o = b7;

endmodule : dps_cmd_decode

// ===== core/dps_core.sv
// module: drive profile power state machine with wishbone registers
// How it works
// - drive profile mode is selected by default after reset
// - commands decode from control bits 7,3,2,1,0 with bit 7 clear
// - control bit 7 set means fault reset, lower bits ignored
// - switch on plus enable passes switched on then enters operation enabled
// - in profile mode a running drive enters operation enabled whatever the source, a stopped one leaves it only without fieldbus control
// - commands change state only when fieldbus control is selected
// - status bit 14 set when drive is not in speed control
// - after reset take transition 0 into not ready and self-initialize
// - drive ready moves not ready into switch on disabled
// - transition 4 enables drive function, transition 5 disables it
// - shutdown from operation enabled stops by ramp or stop function
// - disable voltage from operation enabled stops by coasting or stop function
// - quick stop from operation enabled quick stops and enters quick stop active
// - transitions 7, 10 and 12 change state only
// - any fault enters fault reaction active and stops by stop function
// - fault reset leaves fault only when no fault remains
// - without stop bit support every stop uses the stop function
// - status bits 6,5,3,2,1,0 encode the state
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module dps_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic drive_ready_i,
  input wire logic drive_fault_i,
  input wire logic drive_running_i,
  input wire logic stop_done_i,
  output logic drive_enable_o,
  output logic stop_req_o,
  output logic [1:0] stop_kind_o,
  output logic [15:0] status_word_o
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    dps_pkg::dps_state_t st;
    logic [3:0] init_cnt;
    logic [15:0] cw;
    dps_pkg::dps_cfg_t cfg;
    dps_pkg::dps_act_t act;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] rdy_s;
    logic [2:0] flt_s;
    logic [2:0] run_s;
    logic [2:0] done_s;
    logic rdy;
    logic flt;
    logic run;
    logic done;
  } dps_core_t;

  dps_core_t r;
  dps_core_t next_r;

  logic c_shutdown;
  logic c_switch_on;
  logic c_enable_op;
  logic c_dis_voltage;
  logic c_quick_stop;
  logic c_fault_reset;
  logic [15:0] sw;
  logic acc;

  dps_cmd_decode u_dec (
    .cw_i(r.cw),
    .shutdown_o(c_shutdown),
    .switch_on_o(c_switch_on),
    .enable_op_o(c_enable_op),
    .dis_voltage_o(c_dis_voltage),
    .quick_stop_o(c_quick_stop),
    .fault_reset_o(c_fault_reset)
  );

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [6:0] state_code(input dps_pkg::dps_state_t s);
    case (s)
      dps_pkg::ST_SO_DISABLED: state_code = dps_pkg::SW_SO_DISABLED;
      dps_pkg::ST_READY: state_code = dps_pkg::SW_READY;
      dps_pkg::ST_SWITCHED_ON: state_code = dps_pkg::SW_SWITCHED_ON;
      dps_pkg::ST_OP_ENABLED: state_code = dps_pkg::SW_OP_ENABLED;
      dps_pkg::ST_QSTOP: state_code = dps_pkg::SW_QSTOP;
      dps_pkg::ST_FAULT_REACT: state_code = dps_pkg::SW_FAULT_REACT;
      dps_pkg::ST_FAULT: state_code = dps_pkg::SW_FAULT;
      default: state_code = dps_pkg::SW_NOT_READY;
    endcase
  endfunction : state_code

  function automatic dps_pkg::dps_stop_t pick_stop(input dps_pkg::dps_stop_t k,
                                                   input logic no_bits);
    pick_stop = no_bits ? dps_pkg::STOP_NONE : k;
  endfunction : pick_stop

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  always_comb begin
    sw = 16'h0000;
    sw[6:0] = state_code(r.st) & dps_pkg::SW_STATE_MASK;
    sw[dps_pkg::SW_MODE_BAD] = !r.cfg.speed_mode;
  end

  assign acc = wb_cyc_i && wb_stb_i && !r.ack;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic cmd_ok;
    logic stop_bad;
    cmd_ok = 1'b0;
    stop_bad = 1'b0;
    next_r = r;
    next_r.rdy_s = {r.rdy_s[1:0], drive_ready_i};
    next_r.flt_s = {r.flt_s[1:0], drive_fault_i};
    next_r.run_s = {r.run_s[1:0], drive_running_i};
    next_r.done_s = {r.done_s[1:0], stop_done_i};
    if (r.rdy_s[1] == r.rdy_s[2]) begin
      next_r.rdy = r.rdy_s[2];
    end
    if (r.flt_s[1] == r.flt_s[2]) begin
      next_r.flt = r.flt_s[2];
    end
    if (r.run_s[1] == r.run_s[2]) begin
      next_r.run = r.run_s[2];
    end
    if (r.done_s[1] == r.done_s[2]) begin
      next_r.done = r.done_s[2];
    end
    // bus slave
    next_r.ack = acc;
    if (acc) begin
      next_r.rdat = 32'h0000_0000;
      case (wb_adr_i[31:4] == 28'h000_0000 ? wb_adr_i[3:0] : 4'h1)
        dps_pkg::ADR_CTRL: next_r.rdat = {16'h0000, r.cw};
        dps_pkg::ADR_STAT: next_r.rdat = {16'h0000, sw};
        dps_pkg::ADR_CFG: next_r.rdat = {28'h000_0000, r.cfg};
        dps_pkg::ADR_DRV: next_r.rdat = {28'h000_0000, r.done, r.run, r.flt, r.rdy};
        default: next_r.rdat = 32'h0000_0000;
      endcase
      if (wb_we_i && wb_adr_i[31:4] == 28'h000_0000) begin
        if (wb_adr_i[3:0] == dps_pkg::ADR_CTRL) begin
          if (wb_sel_i[0]) begin
            next_r.cw[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_r.cw[15:8] = wb_dat_i[15:8];
          end
        end
        if (wb_adr_i[3:0] == dps_pkg::ADR_CFG && wb_sel_i[0]) begin
          next_r.cfg = wb_dat_i[3:0];
        end
      end
    end
    cmd_ok = r.cfg.fieldbus && r.cfg.profile_mode;
    stop_bad = r.cfg.no_stop_bits;
    // state machine
    case (r.st)
      dps_pkg::ST_INIT: begin
        next_r.st = dps_pkg::ST_NOT_READY;
        next_r.init_cnt = 4'(dps_pkg::INIT_CYC);
        next_r.act = '0;
      end
      dps_pkg::ST_NOT_READY: begin
        if (r.init_cnt != 4'h0) begin
          next_r.init_cnt = r.init_cnt - 4'h1;
        end else if (r.rdy) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
        end
      end
      dps_pkg::ST_SO_DISABLED: begin
        if (cmd_ok && c_shutdown) begin
          next_r.st = dps_pkg::ST_READY;
        end
      end
      dps_pkg::ST_READY: begin
        if (cmd_ok && (c_dis_voltage || c_quick_stop)) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
        end else if (cmd_ok && (c_switch_on || c_enable_op)) begin
          next_r.st = dps_pkg::ST_SWITCHED_ON;
        end
      end
      dps_pkg::ST_SWITCHED_ON: begin
        if (cmd_ok && (c_dis_voltage || c_quick_stop)) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
        end else if (cmd_ok && c_shutdown) begin
          next_r.st = dps_pkg::ST_READY;
        end else if ((cmd_ok && c_enable_op) || (r.cfg.profile_mode && r.run)) begin
          next_r.st = dps_pkg::ST_OP_ENABLED;
          next_r.act.drive_enable = 1'b1;
        end
      end
      dps_pkg::ST_OP_ENABLED: begin
        if (cmd_ok && c_dis_voltage) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
          next_r.act.drive_enable = 1'b0;
          next_r.act.stop_req = 1'b1;
          next_r.act.stop_kind = pick_stop(dps_pkg::STOP_COAST, stop_bad);
        end else if (cmd_ok && c_quick_stop) begin
          next_r.st = dps_pkg::ST_QSTOP;
          next_r.act.drive_enable = 1'b0;
          next_r.act.stop_req = 1'b1;
          next_r.act.stop_kind = pick_stop(dps_pkg::STOP_QUICK, stop_bad);
        end else if (cmd_ok && c_shutdown) begin
          next_r.st = dps_pkg::ST_READY;
          next_r.act.drive_enable = 1'b0;
          next_r.act.stop_req = 1'b1;
          next_r.act.stop_kind = pick_stop(dps_pkg::STOP_RAMP, stop_bad);
        end else if ((cmd_ok && c_switch_on) ||
                     (r.cfg.profile_mode && !cmd_ok && !r.run)) begin
          next_r.st = dps_pkg::ST_SWITCHED_ON;
          next_r.act.drive_enable = 1'b0;
        end
      end
      dps_pkg::ST_QSTOP: begin
        if (cmd_ok && c_dis_voltage) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
        end else if (cmd_ok && c_enable_op) begin
          next_r.st = dps_pkg::ST_OP_ENABLED;
          next_r.act.drive_enable = 1'b1;
          next_r.act.stop_req = 1'b0;
        end
      end
      dps_pkg::ST_FAULT_REACT: begin
        if (r.done) begin
          next_r.st = dps_pkg::ST_FAULT;
          next_r.act.stop_req = 1'b0;
        end
      end
      dps_pkg::ST_FAULT: begin
        if (c_fault_reset && cmd_ok && !r.flt) begin
          next_r.st = dps_pkg::ST_SO_DISABLED;
        end
      end
      default: next_r.st = dps_pkg::ST_INIT;
    endcase
    if (r.flt && r.st != dps_pkg::ST_FAULT_REACT && r.st != dps_pkg::ST_FAULT &&
        r.st != dps_pkg::ST_INIT) begin
      next_r.st = dps_pkg::ST_FAULT_REACT;
      next_r.act.drive_enable = 1'b0;
      next_r.act.stop_req = 1'b1;
      next_r.act.stop_kind = dps_pkg::STOP_NONE;
    end
    if (next_r.st == dps_pkg::ST_SO_DISABLED || next_r.st == dps_pkg::ST_READY) begin
      if (r.done) begin
        next_r.act.stop_req = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= dps_pkg::ST_INIT;
      r.cfg <= dps_pkg::CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign drive_enable_o = r.act.drive_enable;
  assign stop_req_o = r.act.stop_req;
  assign stop_kind_o = r.act.stop_kind;
  assign status_word_o = sw;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_fault_seen;
    r.flt && r.st == dps_pkg::ST_OP_ENABLED;
  endsequence

  AST_DEFAULT_MODE: assert property (@(posedge clk_i) $fell(rst_i) |->
    r.cfg.profile_mode) else $error("profile mode not default");
  AST_FAULT_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    r.cw[7] |-> c_fault_reset && !c_shutdown && !c_enable_op) else $error("bit7 decode");
  AST_NO_CMD: assert property (@(posedge clk_i) disable iff (rst_i)
    !r.cfg.fieldbus && r.st == dps_pkg::ST_SO_DISABLED |=> r.st != dps_pkg::ST_READY)
    else $error("command acted without fieldbus");
  AST_MODE_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    sw[14] == !r.cfg.speed_mode) else $error("mode bit wrong");
  AST_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == dps_pkg::ST_INIT |=> r.st == dps_pkg::ST_NOT_READY) else $error("no init");
  AST_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == dps_pkg::ST_OP_ENABLED && !$past(r.flt) |-> drive_enable_o)
    else $error("drive not enabled");
  AST_QSTOP: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == dps_pkg::ST_QSTOP |-> stop_req_o || !drive_enable_o) else $error("qstop");
  AST_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fault_seen |=> r.st == dps_pkg::ST_FAULT_REACT && stop_req_o) else $error("fault");
  AST_STATE_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == dps_pkg::ST_FAULT |-> sw[6:0] == 7'h08) else $error("fault code");

endmodule : dps_core

// ===== bench/dps_drive_model.sv
// drive side model: ready report, running level and stop completion
`timescale 1ns/1ps
module dps_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_req_i,
  input wire logic run_i,
  input wire logic [3:0] dly_i,
  output logic ready_o,
  output logic running_o,
  output logic stop_done_o
);
  logic [4:0] cnt = 5'h00;

  initial begin
    ready_o = 1'b0;
    stop_done_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // actual running level as commanded by the bench
  // ---------------------------------------------------------------
  assign running_o = run_i;

  // ---------------------------------------------------------------
  // ready after reset, stop done some cycles after a stop request
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    ready_o <= !rst_i;
    if (rst_i || !stop_req_i) begin
      cnt <= 5'h00;
      stop_done_o <= 1'b0;
    end else if (cnt == {1'b0, dly_i}) begin
      stop_done_o <= 1'b1;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
endmodule : dps_drive_model

// ===== bench/dps_core_tb.sv
// self-checking bench of the drive profile state machine
`timescale 1ns/1ps
module dps_core_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic fault = 1'b0;
  logic run = 1'b0;
  logic [3:0] dly = 4'h8;
  logic [31:0] rdat;
  logic ack, ready, running, done, drv_en, stop_req;
  logic [1:0] kind;
  logic [15:0] sw;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  logic [15:0] cmd_t[3] = '{16'h0006, 16'h0000, 16'h0002};
  logic [6:0] st_t[3] = '{dps_pkg::SW_READY, dps_pkg::SW_SO_DISABLED, dps_pkg::SW_QSTOP};
  logic [1:0] kind_t[3] = '{2'h1, 2'h2, 2'h3};

  always #4 clk_i = ~clk_i;

  dps_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .drive_ready_i(ready), .drive_fault_i(fault),
    .drive_running_i(running), .stop_done_i(done), .drive_enable_o(drv_en),
    .stop_req_o(stop_req), .stop_kind_o(kind), .status_word_o(sw));

  dps_drive_model drv (.clk_i(clk_i), .rst_i(rst_i), .stop_req_i(stop_req), .run_i(run),
    .dly_i(dly), .ready_o(ready), .running_o(running), .stop_done_o(done));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : ck

  task automatic timeout;
    num_errors++;
    $display("wrong value wait expected done seen timeout");
    final_report();
  endtask : timeout

  // ---------------------------------------------------------------
  // wishbone classic cycles
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) timeout();
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd

  task automatic cw(input logic [15:0] v);
    wb(1'b1, {28'h000_0000, dps_pkg::ADR_CTRL}, {16'h0000, v}, 4'h3);
  endtask : cw

  task automatic cfg(input logic [3:0] v);
    wb(1'b1, {28'h000_0000, dps_pkg::ADR_CFG}, {28'h000_0000, v}, 4'h1);
  endtask : cfg

  // ---------------------------------------------------------------
  // state observation
  // ---------------------------------------------------------------
  task automatic st(input logic [6:0] s);
    ck("state", {25'h0, sw[6:0] & dps_pkg::SW_STATE_MASK},
       {25'h0, s & dps_pkg::SW_STATE_MASK});
  endtask : st

  task automatic wait_st(input logic [6:0] s);
    int n;
    for (n = 0; n < 80; n++) begin
      @(negedge clk_i);
      if ((sw[6:0] & dps_pkg::SW_STATE_MASK) === (s & dps_pkg::SW_STATE_MASK)) break;
    end
    if (n == 80) timeout();
    st(s);
  endtask : wait_st

  task automatic to_op;
    int n;
    cw(16'h0000);
    wait_st(dps_pkg::SW_SO_DISABLED);
    for (n = 0; n < 80; n++) begin
      @(negedge clk_i);
      if (stop_req === 1'b0) break;
    end
    if (n == 80) timeout();
    cw(16'h0006);
    wait_st(dps_pkg::SW_READY);
    cw(16'h000F);
    wait_st(dps_pkg::SW_OP_ENABLED);
  endtask : to_op

  // read data checked against the oldest note
  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        ck("read note", 32'h0000_0001, 32'h0000_0000);
      end else begin
        ck("read data", rdat, exp_q.pop_front());
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(28));
    dly <= 4'($urandom_range(8, 15));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    ck("status", {16'h0000, sw}, 32'h0000_0000);
    rd({28'h000_0000, dps_pkg::ADR_CFG}, 32'h0000_000B);
    rd(32'h0000_0010, 32'h0000_0000);
    wait_st(dps_pkg::SW_SO_DISABLED);
    cw(16'h0006);
    wait_st(dps_pkg::SW_READY);
    cw(16'h000F);
    wait_st(dps_pkg::SW_SWITCHED_ON);
    @(negedge clk_i);
    st(dps_pkg::SW_OP_ENABLED);
    repeat (2) @(negedge clk_i);
    ck("enable", {31'h0, drv_en}, 32'h0000_0001);
    cw(16'h0007);
    wait_st(dps_pkg::SW_SWITCHED_ON);
    repeat (2) @(negedge clk_i);
    ck("enable", {31'h0, drv_en}, 32'h0000_0000);
    @(posedge clk_i);
    run <= 1'b1;
    wait_st(dps_pkg::SW_OP_ENABLED);
    @(posedge clk_i);
    run <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      to_op();
      cw(cmd_t[i]);
      wait_st(st_t[i]);
      repeat (2) @(negedge clk_i);
      ck("stop req", {31'h0, stop_req}, 32'h0000_0001);
      ck("stop kind", {30'h0, kind}, {30'h0, kind_t[i]});
    end
    cw(16'h0000);
    wait_st(dps_pkg::SW_SO_DISABLED);
    ck("enable", {31'h0, drv_en}, 32'h0000_0000);
    cfg(4'hF);
    to_op();
    cw(16'h0002);
    wait_st(dps_pkg::SW_QSTOP);
    repeat (2) @(negedge clk_i);
    ck("stop kind", {30'h0, kind}, 32'h0000_0000);
    cfg(4'hB);
    to_op();
    @(posedge clk_i);
    fault <= 1'b1;
    wait_st(dps_pkg::SW_FAULT_REACT);
    ck("stop kind", {30'h0, kind}, 32'h0000_0000);
    wait_st(dps_pkg::SW_FAULT);
    cw(16'h0080 | 16'($urandom_range(0, 127)));
    repeat (12) @(negedge clk_i);
    st(dps_pkg::SW_FAULT);
    @(posedge clk_i);
    fault <= 1'b0;
    repeat (6) @(posedge clk_i);
    cw(16'h0080 | 16'($urandom_range(0, 127)));
    wait_st(dps_pkg::SW_SO_DISABLED);
    cfg(4'hA);
    cw(16'h0006);
    repeat (12) @(negedge clk_i);
    st(dps_pkg::SW_SO_DISABLED);
    cfg(4'h9);
    repeat (2) @(negedge clk_i);
    ck("mode flag", {31'h0, sw[14]}, 32'h0000_0001);
    cfg(4'hB);
    repeat (2) @(negedge clk_i);
    ck("mode flag", {31'h0, sw[14]}, 32'h0000_0000);
    final_report();
  end
endmodule : dps_core_tb
